// >>> rtl/dpsd_defines.svh
// Purpose: Constants of the debug port serial decoder
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef DPSD_DEFINES_SVH
`define DPSD_DEFINES_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define DPSD_DATA_W      32
`define DPSD_FIELD_W     7
`define DPSD_HDR_BITS    3
`define DPSD_CNT_W       6
`define DPSD_LEN_LONG    6'h23
`define DPSD_LEN_SHORT   6'h0A

// ----------------------------------------
// Command and reset values
// ----------------------------------------
`define DPSD_CMD_NOP     7'h00
`define DPSD_CMD_NEGATE  7'h1F
`define DPSD_TRAP_RST    7'h00

`endif

// >>> rtl/dpsd_pkg.sv
// Purpose: Types of the debug port serial decoder
// Assumes: Nothing
// Notes:   Status codes are sent in the two bits right after the ready bit
package dpsd_pkg;

  typedef enum logic [2:0] {
    DPSD_ST_IDLE  = 3'b001,
    DPSD_ST_READY = 3'b010,
    DPSD_ST_SHIFT = 3'b100
  } dpsd_state_e;

  typedef enum logic [1:0] {
    DPSD_STAT_VALID  = 2'b00,
    DPSD_STAT_SEQERR = 2'b01,
    DPSD_STAT_IRQ    = 2'b10,
    DPSD_STAT_NULL   = 2'b11
  } dpsd_status_e;

endpackage

// >>> rtl/dpsd_sync_edge.sv
// Purpose: Two-flop synchronisers for serial clock and data, clock edge finder
// Assumes: mclk_i much faster than the serial clock
// Notes:   Data is taken from the same stage as the clock so both line up
`timescale 1ns/1ps
`default_nettype none
module dpsd_sync_edge
(
  input  wire logic mclk_i,
  input  wire logic nrst_i,
  input  wire logic sck_i,
  input  wire logic sdi_i,
  output logic      rise_o,
  output logic      bit_o
);
  logic [1:0] sck_sync_r;
  logic [1:0] sdi_sync_r;
  logic       sck_last_r;

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sck_sync_r <= 2'h0;
      sdi_sync_r <= 2'h0;
      sck_last_r <= 1'b0;
      rise_o     <= 1'b0;
      bit_o      <= 1'b0;
    end
    else
    begin
      sck_sync_r <= {sck_sync_r[0], sck_i};
      sdi_sync_r <= {sdi_sync_r[0], sdi_i};
      sck_last_r <= sck_sync_r[1];
      rise_o     <= sck_sync_r[1] & ~sck_last_r;
      bit_o      <= sdi_sync_r[1];
    end
  end
endmodule // dpsd_sync_edge
`default_nettype wire

// >>> rtl/dpsd_top.sv
// Purpose: Debug mode serial port: decodes incoming frames, frames outgoing status
// Assumes: Serial clock from the tool is slow against mclk_i (4 cycles or more per half period)
// Notes:
// Function
// [R1] Frame: start one, mode, control, payload
// [R2] Mode zero: instruction or data to CPU
// [R3] Swapped instruction/data reports sequence error next
// [R4] Trap frame loads seven-bit trap enables
// [R5] Command 0011111 negates breakpoint requests
// [R6] Command zero is a null operation
// [R7] Every transmission starts with ready zero
// [R8] Tool waits for output low first
// [R9] Tool sends null while reading responses
// [R10] Commands: negate, reset, fast download on/off
// [R11] Valid data status beats all others
// [R12] Port data write yields valid-data status
// [R13] One bit per clock, decode after last
`timescale 1ns/1ps
`default_nettype none
`include "dpsd_defines.svh"
module dpsd_top
#(
  parameter int          DATA_W       = `DPSD_DATA_W,
  // Only the negate and null codes are fixed; these three defaults are arbitrary
  parameter logic [6:0]  CMD_RESET    = 7'h01,
  parameter logic [6:0]  CMD_FDL_ON   = 7'h02,
  parameter logic [6:0]  CMD_FDL_OFF  = 7'h03
)
(
  input  wire logic                mclk_i,
  input  wire logic                nrst_i,
  input  wire logic                dsck_i,
  input  wire logic                dsdi_i,
  output logic                     serial_debug_out_o,
  input  wire logic                cpu_wait_i,
  input  wire logic                cpu_expect_data_i,
  input  wire logic                cpu_irq_i,
  input  wire logic                cpu_port_data_holding_reg_wr_i,
  input  wire logic [DATA_W-1:0]   cpu_port_data_holding_reg_data_i,
  output logic [DATA_W-1:0]        cpu_word_o,
  output logic                     cpu_instr_vld_o,
  output logic                     cpu_data_vld_o,
  output logic [6:0]               trap_en_o,
  output logic                     brk_negate_o,
  output logic                     cpu_reset_o,
  output logic                     fast_dl_o
);
  import dpsd_pkg::*;

  // Frame counter is sized for a 32-bit payload; free codes must not shadow the fixed ones
  if ((DATA_W != `DPSD_DATA_W) ||
      (CMD_RESET == `DPSD_CMD_NEGATE) || (CMD_FDL_ON == `DPSD_CMD_NEGATE) || (CMD_FDL_OFF == `DPSD_CMD_NEGATE) ||
      (CMD_RESET == `DPSD_CMD_NOP) || (CMD_FDL_ON == `DPSD_CMD_NOP) || (CMD_FDL_OFF == `DPSD_CMD_NOP))
  begin : g_bad_param
    $error("dpsd_top: unsupported parameter value");
  end

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  dpsd_state_e                 state_r;
  logic                        rise;
  logic                        sbit;
  logic [`DPSD_CNT_W-1:0]      cnt_r;
  logic                        mode_r;
  logic                        ctrl_r;
  logic [DATA_W-1:0]           in_sr_r;
  logic [DATA_W+1:0]           out_sr_r;
  logic [DATA_W-1:0]           port_data_holding_reg_r;
  logic                        vld_pend_r;
  logic                        seq_pend_r;
  logic                        irq_pend_r;
  logic                        start_take;
  logic                        last_bit;
  logic                        decode_now;
  logic [6:0]                  field;
  dpsd_status_e                stat;

  dpsd_sync_edge u_sync
  (
    .mclk_i (mclk_i),
    .nrst_i (nrst_i),
    .sck_i  (dsck_i),
    .sdi_i  (dsdi_i),
    .rise_o (rise),
    .bit_o  (sbit)
  );

  // ----------------------------------------
  // Frame sequencing
  // ----------------------------------------
  assign start_take = (state_r == DPSD_ST_READY) && rise && sbit;  // R1
  // Count holds bits received so far, start bit included
  assign last_bit   = (cnt_r >= 6'(`DPSD_HDR_BITS)) &&
                      (cnt_r + 6'h01 == (mode_r ? `DPSD_LEN_SHORT : `DPSD_LEN_LONG));
  assign decode_now = (state_r == DPSD_ST_SHIFT) && rise && last_bit;  // R13
  // Payload bits 0:6 are the first seven shifted after the header
  assign field      = mode_r ? {in_sr_r[5:0], sbit} : in_sr_r[DATA_W-1 -: 7];

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      state_r <= DPSD_ST_IDLE;
    else
    begin
      unique case (state_r)
        DPSD_ST_IDLE:
          if (cpu_wait_i)
            state_r <= DPSD_ST_READY;
        DPSD_ST_READY:
          if (start_take)
            state_r <= DPSD_ST_SHIFT;  // R8
        DPSD_ST_SHIFT:
          if (decode_now)
            state_r <= DPSD_ST_IDLE;
        default:
          state_r <= DPSD_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cnt_r   <= '0;
      mode_r  <= 1'b0;
      ctrl_r  <= 1'b0;
      in_sr_r <= '0;
    end
    else if (start_take)
    begin
      cnt_r   <= 6'h01;
      mode_r  <= 1'b0;
      ctrl_r  <= 1'b0;
    end
    else if ((state_r == DPSD_ST_SHIFT) && rise)
    begin
      cnt_r <= cnt_r + 6'h01;  // R13
      if (cnt_r == 6'h01)
        mode_r <= sbit;
      else if (cnt_r == 6'h02)
        ctrl_r <= sbit;
      else
        in_sr_r <= {in_sr_r[DATA_W-2:0], sbit};
    end
  end

  // ----------------------------------------
  // Outgoing status and data
  // ----------------------------------------
  always_comb
  begin
    if (vld_pend_r)
      stat = DPSD_STAT_VALID;  // R11
    else if (seq_pend_r)
      stat = DPSD_STAT_SEQERR;
    else if (irq_pend_r)
      stat = DPSD_STAT_IRQ;
    else
      stat = DPSD_STAT_NULL;
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      out_sr_r           <= '1;
      serial_debug_out_o <= 1'b1;
    end
    else if (start_take)
    begin
      out_sr_r           <= {stat, (vld_pend_r ? port_data_holding_reg_r : {DATA_W{1'b0}})};
      serial_debug_out_o <= stat[1];
    end
    else if ((state_r == DPSD_ST_SHIFT) && rise)
    begin
      out_sr_r           <= {out_sr_r[DATA_W:0], 1'b1};
      serial_debug_out_o <= decode_now ? 1'b1 : out_sr_r[DATA_W];
    end
    else if (state_r == DPSD_ST_READY)
      serial_debug_out_o <= 1'b0;  // R7
    else if (state_r == DPSD_ST_IDLE)
      serial_debug_out_o <= 1'b1;
  end

  // Pending flags: a new event in the taking cycle survives the clear
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      port_data_holding_reg_r <= '0;
      vld_pend_r              <= 1'b0;
      irq_pend_r              <= 1'b0;
    end
    else
    begin
      if (cpu_port_data_holding_reg_wr_i)
      begin
        port_data_holding_reg_r <= cpu_port_data_holding_reg_data_i;  // R12
        vld_pend_r              <= 1'b1;
      end
      else if (start_take)
        vld_pend_r <= 1'b0;
      if (cpu_irq_i)
        irq_pend_r <= 1'b1;
      else if (start_take && !vld_pend_r)
        irq_pend_r <= 1'b0;  // R11
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      seq_pend_r <= 1'b0;
    else if (decode_now && !mode_r && (ctrl_r != cpu_expect_data_i))
      seq_pend_r <= 1'b1;  // R3
    else if (start_take && !vld_pend_r)
      seq_pend_r <= 1'b0;
  end

  // ----------------------------------------
  // Decode of the received frame
  // ----------------------------------------
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      cpu_word_o      <= '0;
      cpu_instr_vld_o <= 1'b0;
      cpu_data_vld_o  <= 1'b0;
    end
    else
    begin
      cpu_instr_vld_o <= 1'b0;
      cpu_data_vld_o  <= 1'b0;
      if (decode_now && !mode_r && (ctrl_r == cpu_expect_data_i))
      begin
        cpu_word_o      <= {in_sr_r[DATA_W-2:0], sbit};  // R2
        cpu_instr_vld_o <= ~ctrl_r;
        cpu_data_vld_o  <= ctrl_r;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      trap_en_o    <= `DPSD_TRAP_RST;
      brk_negate_o <= 1'b0;
      cpu_reset_o  <= 1'b0;
      fast_dl_o    <= 1'b0;
    end
    else
    begin
      brk_negate_o <= 1'b0;
      cpu_reset_o  <= 1'b0;
      if (decode_now && mode_r && !ctrl_r)
        trap_en_o <= field;  // R4
      if (decode_now && mode_r && ctrl_r)
      begin
        // Codes not listed, null included, change nothing
        if (field == `DPSD_CMD_NEGATE)
          brk_negate_o <= 1'b1;  // R5
        else if (field == CMD_RESET)
          cpu_reset_o <= 1'b1;  // R10
        else if (field == CMD_FDL_ON)
          fast_dl_o <= 1'b1;  // R10
        else if (field == CMD_FDL_OFF)
          fast_dl_o <= 1'b0;  // R10
        else if (field == `DPSD_CMD_NOP)
          fast_dl_o <= fast_dl_o;  // R6
      end
    end
  end

endmodule // dpsd_top
`default_nettype wire

// >>> bench/dpsd_tool_model.sv
// Purpose: Development tool shifting frames into the debug port
// Assumes: 80 ns bit period, clock low between frames
// Notes:   rx holds the bits seen on the serial output at each rise
`timescale 1ns/1ps
`default_nettype none
module dpsd_tool_model
(
  input  wire logic sdo_i,
  output logic      sck_o,
  output logic      sdi_o
);
  logic [34:0] rx;
  initial sck_o = 1'b0;
  initial sdi_o = 1'b0;
  task automatic send(input logic [34:0] f, input int n);
    int k;
    k = 0;
    // Step off the system clock edge so pin changes never race the synchronisers
    #1;
    while (sdo_i !== 1'b0 && k < 500)
    begin
      #4;
      k++;
    end
    for (int i = 0; i < n; i++)
    begin
      sdi_o = f[34-i];
      #40 sck_o = 1'b1;
      rx[34-i] = sdo_i;
      #40 sck_o = 1'b0;
    end
    // Released line must not keep looking valid
    sdi_o = ~sdi_o;
  endtask
endmodule // dpsd_tool_model
`default_nettype wire

// >>> bench/dpsd_top_properties.sv
// Purpose: Port assertions of the debug port serial decoder
// Assumes: Bound to dpsd_top
// Notes:   Results land in the same cycle as the frame end raises the output
`timescale 1ns/1ps
`default_nettype none
module dpsd_top_checker
#(
  parameter int DATA_W = 32
)
(
  input wire logic              mclk_i,
  input wire logic              nrst_i,
  input wire logic              serial_debug_out_o,
  input wire logic              cpu_expect_data_i,
  input wire logic [DATA_W-1:0] cpu_word_o,
  input wire logic              cpu_instr_vld_o,
  input wire logic              cpu_data_vld_o,
  input wire logic [6:0]        trap_en_o,
  input wire logic              brk_negate_o,
  input wire logic              fast_dl_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  logic vld;
  assign vld = cpu_instr_vld_o | cpu_data_vld_o;
  instr_in_seq_a: assert property (cpu_instr_vld_o |-> !$past(cpu_expect_data_i))
    else $error("instruction passed while data expected");
  data_in_seq_a: assert property (cpu_data_vld_o |-> $past(cpu_expect_data_i))
    else $error("data passed while instruction expected");
  vld_exclusive_a: assert property (cpu_instr_vld_o |-> !cpu_data_vld_o)
    else $error("both kinds flagged");
  word_with_vld_a: assert property ($changed(cpu_word_o) |-> vld)
    else $error("word changed without a flag");
  pulse_after_end_a: assert property (vld || brk_negate_o |-> serial_debug_out_o)
    else $error("result before frame end");
  trap_after_end_a: assert property ($changed(trap_en_o) |-> serial_debug_out_o && !vld)
    else $error("trap enables changed mid frame");
  brk_one_cycle_a: assert property (brk_negate_o |=> !brk_negate_o [*2])
    else $error("negate pulse too long");
  fdl_after_end_a: assert property ($changed(fast_dl_o) |-> serial_debug_out_o)
    else $error("download flag changed mid frame");
endmodule // dpsd_top_checker
bind dpsd_top dpsd_top_checker #(.DATA_W(DATA_W)) i_chk
(
  .mclk_i             (mclk_i),
  .nrst_i             (nrst_i),
  .serial_debug_out_o (serial_debug_out_o),
  .cpu_expect_data_i  (cpu_expect_data_i),
  .cpu_word_o         (cpu_word_o),
  .cpu_instr_vld_o    (cpu_instr_vld_o),
  .cpu_data_vld_o     (cpu_data_vld_o),
  .trap_en_o          (trap_en_o),
  .brk_negate_o       (brk_negate_o),
  .fast_dl_o          (fast_dl_o)
);
`default_nettype wire

// >>> bench/tb.sv
// Purpose: Self-checking bench of the debug port serial decoder
// Assumes: Tool model shifts frames at 80 ns per bit
// Notes:   Rows hold plain frames; swapped frames and valid data by hand
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dpsd_pkg::*;
  logic mclk_i = 0, nrst_i = 0, cpu_wait_i = 0, cpu_expect_data_i = 0, cpu_irq_i = 0, cpu_port_data_holding_reg_wr_i = 0;
  logic dsck_i, dsdi_i, serial_debug_out_o, cpu_instr_vld_o, cpu_data_vld_o, brk_negate_o, cpu_reset_o, fast_dl_o;
  logic [31:0] cpu_port_data_holding_reg_data_i = 32'h0, cpu_word_o;
  logic [6:0]  trap_en_o;
  logic [3:0]  ci = 0, cd = 0, cb = 0, cr = 0;
  int          errors = 0, compares = 0, cyc = 0;
  typedef struct {logic [34:0] f; logic x; logic [55:0] e;} dpsd_row_s;
  dpsd_row_s   rows [9];
  always #2 mclk_i = ~mclk_i;
  dpsd_top i_dut
  (
    .mclk_i             (mclk_i),
    .nrst_i             (nrst_i),
    .dsck_i             (dsck_i),
    .dsdi_i             (dsdi_i),
    .serial_debug_out_o (serial_debug_out_o),
    .cpu_wait_i         (cpu_wait_i),
    .cpu_expect_data_i  (cpu_expect_data_i),
    .cpu_irq_i          (cpu_irq_i),
    .cpu_port_data_holding_reg_wr_i      (cpu_port_data_holding_reg_wr_i),
    .cpu_port_data_holding_reg_data_i    (cpu_port_data_holding_reg_data_i),
    .cpu_word_o         (cpu_word_o),
    .cpu_instr_vld_o    (cpu_instr_vld_o),
    .cpu_data_vld_o     (cpu_data_vld_o),
    .trap_en_o          (trap_en_o),
    .brk_negate_o       (brk_negate_o),
    .cpu_reset_o        (cpu_reset_o),
    .fast_dl_o          (fast_dl_o)
  );
  dpsd_tool_model i_tool (.sdo_i(serial_debug_out_o), .sck_o(dsck_i), .sdi_o(dsdi_i));
  function automatic logic [34:0] fl(logic c, logic [31:0] p);
    return {2'b10, c, p};
  endfunction
  function automatic logic [34:0] fs(logic c, logic [6:0] p);
    return {2'b11, c, p, 25'h0};
  endfunction
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic go(input logic [34:0] f);
    i_tool.send(f, f[33] ? 10 : 35);
    repeat (8) @(posedge mclk_i);
    chk(i_tool.rx[34], 1'b0);
    $display("frame %h done", f);
  endtask
  always @(posedge mclk_i)
  begin
    ci <= ci + 4'(cpu_instr_vld_o === 1'b1);
    cd <= cd + 4'(cpu_data_vld_o === 1'b1);
    cb <= cb + 4'(brk_negate_o === 1'b1);
    cr <= cr + 4'(cpu_reset_o === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      errors++;
      conclude();
    end
  end
  initial
  begin
    rows[0] = '{fl(1'b0, 32'h7C0802A6), 1'b0, {32'h7C0802A6, 7'h00, 1'b0, 16'h1000}};
    rows[1] = '{fl(1'b1, 32'h80000001), 1'b1, {32'h80000001, 7'h00, 1'b0, 16'h1100}};
    rows[2] = '{fs(1'b0, 7'h55), 1'b1, {32'h80000001, 7'h55, 1'b0, 16'h1100}};
    rows[3] = '{fs(1'b1, 7'h1F), 1'b1, {32'h80000001, 7'h55, 1'b0, 16'h1110}};
    rows[4] = '{fs(1'b1, 7'h00), 1'b1, {32'h80000001, 7'h55, 1'b0, 16'h1110}};
    rows[5] = '{fs(1'b1, 7'h01), 1'b1, {32'h80000001, 7'h55, 1'b0, 16'h1111}};
    rows[6] = '{fs(1'b1, 7'h02), 1'b1, {32'h80000001, 7'h55, 1'b1, 16'h1111}};
    rows[7] = '{fs(1'b1, 7'h40), 1'b1, {32'h80000001, 7'h55, 1'b1, 16'h1111}};
    rows[8] = '{fs(1'b1, 7'h03), 1'b1, {32'h80000001, 7'h55, 1'b0, 16'h1111}};
    repeat (10) @(posedge mclk_i);
    chk({serial_debug_out_o, trap_en_o, fast_dl_o, cpu_word_o}, {1'b1, 40'h0});
    $display("reset test done");
    repeat (10) @(posedge mclk_i);
    nrst_i <= 1'b1;
    cpu_wait_i <= 1'b1;
    foreach (rows[k])
    begin
      @(posedge mclk_i);
      cpu_expect_data_i <= rows[k].x;
      go(rows[k].f);
      chk({cpu_word_o, trap_en_o, fast_dl_o, ci, cd, cb, cr}, rows[k].e);
      chk(i_tool.rx[33:32], DPSD_STAT_NULL);
    end
    // Instruction while data is expected is dropped
    go(fl(1'b0, 32'h12345678));
    chk({ci, cpu_word_o}, {4'h1, 32'h80000001});
    go(fs(1'b1, 7'h00));
    chk(i_tool.rx[33:32], DPSD_STAT_SEQERR);
    // Valid data and an interrupt in the same cycle
    @(posedge mclk_i);
    cpu_expect_data_i <= 1'b0;
    cpu_port_data_holding_reg_wr_i <= 1'b1;
    cpu_irq_i <= 1'b1;
    cpu_port_data_holding_reg_data_i <= 32'hA5C30F96;
    @(posedge mclk_i);
    cpu_port_data_holding_reg_wr_i <= 1'b0;
    cpu_irq_i <= 1'b0;
    go(fl(1'b0, 32'h60000000));
    chk(i_tool.rx[33:0], {DPSD_STAT_VALID, 32'hA5C30F96});
    go(fs(1'b1, 7'h00));
    chk(i_tool.rx[33:32], DPSD_STAT_IRQ);
    // Reset in mid-run with the CPU not reading: the port must stay not ready
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    cpu_wait_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    chk({serial_debug_out_o, trap_en_o, fast_dl_o, cpu_word_o}, {1'b1, 40'h0});
    nrst_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    chk(serial_debug_out_o, 1'b1);
    cpu_wait_i <= 1'b1;
    go(fs(1'b1, 7'h00));
    chk(i_tool.rx[33:32], DPSD_STAT_NULL);
    $display("mid-run reset done");
    conclude();
  end
endmodule // tb
`default_nettype wire
